// *** src/ifc_interface_feature_config.sv ***
`timescale 1ns/1ps
// How it works
// - Select code 0x04 enables digital I/O, 0x05 SPI slave, 0x07 port-3 bridge.
// - Code 0x10 gives 32 inputs/0 outputs; 0x11 gives 24 inputs/8 outputs.
// - Mirror bit 0 clear: host sets report; set: report copies request.
// - Bit 1 set enables enhanced link on all ports, overriding bits 7:4.
// - Bits 4-7 enable enhanced link per port 0-3 while bit 1 clear.
// - Bit 2 clear powers down sync output unit; set runs it.
// - Bit 3 clear powers down latch input unit; set runs it.
// - Link bits 1 and 7:4 load from EEPROM only on first load.
// - Core: mirror set 1 after reset release with digital I/O, else strap with MCU/bus.
// - While mirroring, every network request write is taken and copied.
module ifc_interface_feature_config
  import ifc_pkg::*;
#(
  parameter ifc_variant_t VARIANT        = IFC_FIXED_SILICON,
  parameter logic [7:0]   CORE_SELECT    = SEL_DIGITAL_IO,
  parameter logic         CORE_SYNC_OUT  = 1'b1,
  parameter logic         CORE_LATCH_IN  = 1'b1,
  parameter int           LINK_PORTS     = 4
)(
  input  wire logic        clock,
  input  wire logic        reset,
  // Configuration EEPROM loader
  input  wire logic        eeprom_load,
  input  wire logic [15:0] eeprom_word0,
  input  wire logic        state_mirror_strap_pin,
  // Network side access
  input  wire logic        network_side_read,
  input  wire logic        network_side_write,
  input  wire logic [15:0] network_side_addr,
  input  wire logic [7:0]  network_side_wdata,
  output logic      [7:0]  network_side_rdata,
  // Host data port access
  input  wire logic        host_data_port_read,
  input  wire logic        host_data_port_write,
  input  wire logic [15:0] host_data_port_addr,
  input  wire logic [7:0]  host_data_port_wdata,
  output logic      [7:0]  host_data_port_rdata,
  // Decoded interface selection
  output logic             digital_io_enable,
  output logic             spi_slave_enable,
  output logic             bridge_port3_enable,
  output logic             oversample_enable,
  output logic             mcu_enable,
  output logic             on_chip_bus_enable,
  output logic             fixed_split_enable,
  output logic      [5:0]  fixed_input_count,
  output logic      [5:0]  fixed_output_count,
  // Feature controls
  output logic      [3:0]  link_enhanced,
  output logic             sync_out_run,
  output logic             latch_in_run,
  output logic             state_mirror_on,
  output logic      [7:0]  state_request,
  output logic      [7:0]  state_report
);

  // ***************************************************
  // Elaboration checks
  // ***************************************************
  if (LINK_PORTS != 4)
    $error("ifc_interface_feature_config: LINK_PORTS must be 4");

  // ***************************************************
  // Functions
  // ***************************************************
  function automatic logic [11:0] split_counts(input logic [7:0] code);
    logic [11:0] counts;
    counts = 12'h000;
    unique case (code)
      SEL_IN4:        counts = {6'd4,  6'd0};
      SEL_OUT4:       counts = {6'd0,  6'd4};
      SEL_IN2_OUT2:   counts = {6'd2,  6'd2};
      SEL_IN32_OUT0:  counts = {6'd32, 6'd0};
      SEL_IN24_OUT8:  counts = {6'd24, 6'd8};
      SEL_IN16_OUT16: counts = {6'd16, 6'd16};
      SEL_IN8_OUT24:  counts = {6'd8,  6'd24};
      SEL_IN0_OUT32:  counts = {6'd0,  6'd32};
      default:        counts = 12'h000;
    endcase
    return counts;
  endfunction

  function automatic logic is_split(input logic [7:0] code);
    return (code >= SEL_IN4 && code <= SEL_IN2_OUT2) ||
           (code >= SEL_IN32_OUT0 && code <= SEL_IN0_OUT32);
  endfunction

  function automatic logic is_mcu_or_bus(input logic [7:0] code);
    return (code >= SEL_MCU_FIRST && code <= SEL_MCU_LAST) ||
           (code == SEL_ON_CHIP_BUS);
  endfunction

  // ***************************************************
  // Configuration state
  // ***************************************************
  logic [7:0] host_interface_select;
  logic [7:0] core_feature_config;
  logic       first_load_done;
  logic       strap_taken;

  wire  [7:0] eeprom_select  = eeprom_word0[7:0];
  wire  [7:0] eeprom_feature = eeprom_word0[15:8];
  wire        is_core        = (VARIANT == IFC_CORE);

  // Core mirror value, picked once after reset release
  wire        core_mirror    =
    (CORE_SELECT == SEL_DIGITAL_IO)  ? 1'b1 :
    is_mcu_or_bus(CORE_SELECT)       ? state_mirror_strap_pin :
                                       MIRROR_RST;

  // Link bits only on the first load, so a reload cannot drop links
  wire        take_link      = eeprom_load && !first_load_done;
  wire        take_silicon   = eeprom_load && !is_core;

  wire        next_mirror    =
    (is_core && !strap_taken) ? core_mirror :
    take_silicon ? eeprom_feature[MIRROR_BIT] :
    core_feature_config[MIRROR_BIT];
  wire        next_sync      =
    take_silicon ? eeprom_feature[SYNC_OUT_BIT] :
    core_feature_config[SYNC_OUT_BIT];
  wire        next_latch     =
    take_silicon ? eeprom_feature[LATCH_IN_BIT] :
    core_feature_config[LATCH_IN_BIT];
  wire        next_link_all  =
    take_link ? eeprom_feature[LINK_ALL_BIT] :
    core_feature_config[LINK_ALL_BIT];
  wire  [3:0] next_link_port =
    take_link ? eeprom_feature[LINK_HI_BIT:LINK_LO_BIT] :
    core_feature_config[LINK_HI_BIT:LINK_LO_BIT];
  wire  [7:0] next_select    =
    take_silicon ? eeprom_select : host_interface_select;

  // ***************************************************
  // Registers: only reset, the loader and the core parameters and strap write them
  // ***************************************************
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      host_interface_select <= HOST_INTERFACE_SELECT_RST;
      core_feature_config   <= {LINK_PORT_RST, LATCH_IN_RST,
                                SYNC_OUT_RST, LINK_ALL_RST, MIRROR_RST};
      first_load_done       <= 1'b0;
      strap_taken           <= 1'b0;
    end
    else
    begin
      host_interface_select <= is_core ? CORE_SELECT : next_select;
      core_feature_config   <= {next_link_port,
                                is_core ? CORE_LATCH_IN : next_latch,
                                is_core ? CORE_SYNC_OUT : next_sync,
                                next_link_all, next_mirror};
      first_load_done       <= first_load_done | eeprom_load;
      strap_taken           <= 1'b1;
    end
  end

  // ***************************************************
  // Interface decode
  // ***************************************************
  wire [11:0] counts = split_counts(host_interface_select);

  assign digital_io_enable   = host_interface_select == SEL_DIGITAL_IO;
  assign spi_slave_enable    = host_interface_select == SEL_SPI_SLAVE;
  assign bridge_port3_enable = host_interface_select == SEL_BRIDGE_P3;
  assign oversample_enable   = host_interface_select == SEL_OVERSAMPLE;
  assign mcu_enable          = is_mcu_or_bus(host_interface_select) &&
                               host_interface_select != SEL_ON_CHIP_BUS;
  assign on_chip_bus_enable  = host_interface_select == SEL_ON_CHIP_BUS;
  assign fixed_split_enable  = is_split(host_interface_select);
  assign fixed_input_count   = counts[11:6];
  assign fixed_output_count  = counts[5:0];

  // ***************************************************
  // Feature decode
  // ***************************************************
  wire link_all = core_feature_config[LINK_ALL_BIT];

  assign link_enhanced   = link_all ? 4'hf
                         : core_feature_config[LINK_HI_BIT:LINK_LO_BIT];
  assign sync_out_run    = core_feature_config[SYNC_OUT_BIT];
  assign latch_in_run    = core_feature_config[LATCH_IN_BIT];
  assign state_mirror_on = core_feature_config[MIRROR_BIT];

  // ***************************************************
  // State request and report pair
  // ***************************************************
  wire net_request_write  = network_side_write &&
                            network_side_addr == STATE_REQUEST_REGISTER_OFS;
  wire host_report_write  = host_data_port_write &&
                            host_data_port_addr == STATE_REPORT_REGISTER_OFS;

  ifc_state_mirror u_mirror
  (
    .clock         (clock),
    .reset         (reset),
    .mirror_on     (state_mirror_on),
    .request_write (net_request_write),
    .request_data  (network_side_wdata),
    .report_write  (host_report_write),
    .report_data   (host_data_port_wdata),
    .state_request (state_request),
    .state_report  (state_report)
  );

  // ***************************************************
  // Read ports
  // ***************************************************
  function automatic logic [7:0] read_mux(input logic [15:0] addr);
    logic [7:0] data;
    data = UNMAPPED_READ;
    unique case (addr)
      HOST_INTERFACE_SELECT_OFS:  data = host_interface_select;
      CORE_FEATURE_CONFIG_OFS:    data = core_feature_config;
      STATE_REQUEST_REGISTER_OFS: data = state_request;
      STATE_REPORT_REGISTER_OFS:  data = state_report;
      default:                    data = UNMAPPED_READ;
    endcase
    return data;
  endfunction

  wire [7:0] next_net_rdata  = network_side_read ?
                               read_mux(network_side_addr) : network_side_rdata;
  wire [7:0] next_host_rdata = host_data_port_read ?
                               read_mux(host_data_port_addr) :
                               host_data_port_rdata;

  // Read data held until the next read, so a slow reader needs no strobe
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      network_side_rdata   <= UNMAPPED_READ;
      host_data_port_rdata <= UNMAPPED_READ;
    end
    else
    begin
      network_side_rdata   <= next_net_rdata;
      host_data_port_rdata <= next_host_rdata;
    end
  end

endmodule // ifc_interface_feature_config

// *** src/ifc_pkg.sv ***
package ifc_pkg;

  // ***************************************************
  // Register offsets (byte addresses)
  // ***************************************************
  localparam logic [15:0] HOST_INTERFACE_SELECT_OFS  = 16'h0140;
  localparam logic [15:0] CORE_FEATURE_CONFIG_OFS    = 16'h0141;
  localparam logic [15:0] STATE_REQUEST_REGISTER_OFS = 16'h0120;
  localparam logic [15:0] STATE_REPORT_REGISTER_OFS  = 16'h0130;

  // ***************************************************
  // Reset values
  // ***************************************************
  localparam logic [7:0] HOST_INTERFACE_SELECT_RST = 8'h00;
  localparam logic [7:0] STATE_REQUEST_RST         = 8'h00;
  localparam logic [7:0] STATE_REPORT_RST          = 8'h01;
  localparam logic       MIRROR_RST                = 1'b0;
  localparam logic       LINK_ALL_RST              = 1'b1;
  localparam logic [3:0] LINK_PORT_RST             = 4'hf;
  localparam logic       SYNC_OUT_RST              = 1'b0;
  localparam logic       LATCH_IN_RST              = 1'b0;
  localparam logic [7:0] UNMAPPED_READ             = 8'h00;

  // ***************************************************
  // Feature field positions
  // ***************************************************
  localparam int MIRROR_BIT   = 0;
  localparam int LINK_ALL_BIT = 1;
  localparam int SYNC_OUT_BIT = 2;
  localparam int LATCH_IN_BIT = 3;
  localparam int LINK_LO_BIT  = 4;
  localparam int LINK_HI_BIT  = 7;

  // ***************************************************
  // Interface select codes
  // ***************************************************
  localparam logic [7:0] SEL_NONE        = 8'h00;
  localparam logic [7:0] SEL_IN4         = 8'h01;
  localparam logic [7:0] SEL_OUT4        = 8'h02;
  localparam logic [7:0] SEL_IN2_OUT2    = 8'h03;
  localparam logic [7:0] SEL_DIGITAL_IO  = 8'h04;
  localparam logic [7:0] SEL_SPI_SLAVE   = 8'h05;
  localparam logic [7:0] SEL_OVERSAMPLE  = 8'h06;
  localparam logic [7:0] SEL_BRIDGE_P3   = 8'h07;
  localparam logic [7:0] SEL_MCU_FIRST   = 8'h08;
  localparam logic [7:0] SEL_MCU_LAST    = 8'h0b;
  localparam logic [7:0] SEL_IN32_OUT0   = 8'h10;
  localparam logic [7:0] SEL_IN24_OUT8   = 8'h11;
  localparam logic [7:0] SEL_IN16_OUT16  = 8'h12;
  localparam logic [7:0] SEL_IN8_OUT24   = 8'h13;
  localparam logic [7:0] SEL_IN0_OUT32   = 8'h14;
  localparam logic [7:0] SEL_ON_CHIP_BUS = 8'h80;

  // Silicon variant
  typedef enum logic {IFC_FIXED_SILICON, IFC_CORE} ifc_variant_t;

endpackage

// *** src/ifc_state_mirror.sv ***
`timescale 1ns/1ps
module ifc_state_mirror
  import ifc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       mirror_on,
  input  wire logic       request_write,
  input  wire logic [7:0] request_data,
  input  wire logic       report_write,
  input  wire logic [7:0] report_data,
  output logic      [7:0] state_request,
  output logic      [7:0] state_report
);

  // ***************************************************
  // Next values
  // ***************************************************
  // Host writes lose when mirroring, so the report never splits
  wire       host_sets   = report_write && !mirror_on;
  wire       net_copies  = request_write && mirror_on;
  wire [7:0] next_report = net_copies ? request_data
                         : host_sets  ? report_data
                         : state_report;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_request <= STATE_REQUEST_RST;
      state_report  <= STATE_REPORT_RST;
    end
    else
    begin
      if (request_write)
        state_request <= request_data;
      state_report <= next_report;
    end
  end

endmodule // ifc_state_mirror

// *** tb/ifc_eeprom_model.sv ***
`timescale 1ns/1ps
// ****
// EEPROM loader model
// ****
module ifc_eeprom_model (
  input  wire logic        clock,
  output logic             eeprom_load,
  output logic      [15:0] eeprom_word0
);
  initial eeprom_load = 1'b0;
  initial eeprom_word0 = 16'h0000;
  // Word valid one cycle only; inverted after so stale data cannot pass
  task automatic load(input logic [15:0] w);
    @(posedge clock);
    eeprom_load <= 1'b1;
    eeprom_word0 <= w;
    @(posedge clock);
    eeprom_load <= 1'b0;
    eeprom_word0 <= ~w;
  endtask
endmodule // ifc_eeprom_model

// *** tb/ifc_interface_feature_config_checker.sv ***
`timescale 1ns/1ps
// ****
// Config register checks
// ****
module ifc_interface_feature_config_checker
  import ifc_pkg::*;
#(
  parameter ifc_variant_t VARIANT = IFC_FIXED_SILICON
)(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        eeprom_load,
  input wire logic [15:0] eeprom_word0,
  input wire logic        network_side_write,
  input wire logic [15:0] network_side_addr,
  input wire logic [7:0]  network_side_wdata,
  input wire logic        host_data_port_write,
  input wire logic [15:0] host_data_port_addr,
  input wire logic [7:0]  host_data_port_wdata,
  input wire logic        digital_io_enable,
  input wire logic        spi_slave_enable,
  input wire logic        bridge_port3_enable,
  input wire logic [5:0]  fixed_input_count,
  input wire logic [5:0]  fixed_output_count,
  input wire logic [3:0]  link_enhanced,
  input wire logic        sync_out_run,
  input wire logic        latch_in_run,
  input wire logic        state_mirror_on,
  input wire logic [7:0]  state_report
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire logic [7:0] sel = eeprom_word0[7:0];
  // Core variant keeps its select and unit bits, so loads decode only here
  wire logic ld_fx = eeprom_load && (VARIANT == IFC_FIXED_SILICON);
  wire logic [2:0] units = {latch_in_run, sync_out_run, state_mirror_on};
  wire logic [2:0] ee_units = {eeprom_word0[11:10], eeprom_word0[8]};
  wire logic [1:0] spi_br = {spi_slave_enable, bridge_port3_enable};
  wire logic [7:0] ctl = {link_enhanced, units, digital_io_enable};
  wire logic net_req = network_side_write &&
    network_side_addr == STATE_REQUEST_REGISTER_OFS;
  wire logic host_rep = host_data_port_write &&
    host_data_port_addr == STATE_REPORT_REGISTER_OFS;
  // A load in the same cycle may legally move the controls
  wire logic cfg_wr =
    (network_side_write && network_side_addr[15:1] == 15'h00a0) ||
    (host_data_port_write && host_data_port_addr[15:1] == 15'h00a0);
  property p_dio;
    ld_fx |=> digital_io_enable == ($past(sel) == 8'h04); endproperty
  a_dio: assert property (p_dio) else $error("io decode wrong");
  property p_spi_br;
    ld_fx |=> spi_br == {$past(sel) == 8'h05, $past(sel) == 8'h07};
  endproperty
  a_spi_br: assert property (p_spi_br) else $error("spi decode wrong");
  property p_split32; ld_fx && sel == 8'h10 |=>
    fixed_input_count == 6'h20 && fixed_output_count == 6'h00; endproperty
  a_split32: assert property (p_split32) else $error("split 32 wrong");
  property p_split24; ld_fx && sel == 8'h11 |=>
    fixed_input_count == 6'h18 && fixed_output_count == 6'h08; endproperty
  a_split24: assert property (p_split24) else $error("split 24 wrong");
  property p_units; ld_fx |=> units == $past(ee_units); endproperty
  a_units: assert property (p_units) else $error("unit bits wrong");
  property p_rst; $fell(reset) |-> link_enhanced == 4'hf && units == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_mirror; state_mirror_on && net_req |=>
    state_report == $past(network_side_wdata); endproperty
  a_mirror: assert property (p_mirror) else $error("no mirror copy");
  property p_host; !state_mirror_on && host_rep |=>
    state_report == $past(host_data_port_wdata); endproperty
  a_host: assert property (p_host) else $error("host report lost");
  property p_ro; cfg_wr && !eeprom_load |=> $stable(ctl); endproperty
  a_ro: assert property (p_ro) else $error("config changed by write");
  c_mirror: cover property (state_mirror_on && net_req);
  c_split: cover property (eeprom_load && sel == 8'h11);
  c_ro: cover property (cfg_wr);
endmodule // ifc_interface_feature_config_checker

bind ifc_interface_feature_config
  ifc_interface_feature_config_checker #(.VARIANT(VARIANT)) u_chk (.*);

// *** tb/ifc_interface_feature_config_tb.sv ***
`timescale 1ns/1ps
// ****
// Config register bench
// ****
module ifc_interface_feature_config_tb;
  import ifc_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        state_mirror_strap_pin = 1'b0;
  logic        network_side_read = 1'b0, network_side_write = 1'b0;
  logic        host_data_port_read = 1'b0, host_data_port_write = 1'b0;
  logic [15:0] network_side_addr = 16'h0000, host_data_port_addr = 16'h0000;
  logic [7:0]  network_side_wdata = 8'h00, host_data_port_wdata = 8'h00;
  logic        eeprom_load, oversample_enable, mcu_enable, on_chip_bus_enable;
  logic [15:0] eeprom_word0;
  logic [7:0]  network_side_rdata, host_data_port_rdata, state_request;
  logic [7:0]  state_report, c;
  logic        digital_io_enable, spi_slave_enable, bridge_port3_enable;
  logic        fixed_split_enable, sync_out_run, latch_in_run, state_mirror_on;
  logic [5:0]  fixed_input_count, fixed_output_count;
  logic [3:0]  link_enhanced;
  logic [7:0]  codes [8] = '{8'h06, 8'h08, 8'h80, 8'h04, 8'h05, 8'h07,
                             8'h10, 8'h11};
  logic [7:0]  ins [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h20, 8'h18};
  logic [7:0]  outs [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                            8'h00, 8'h08};
  wire logic [7:0] io_sel = {1'b0, on_chip_bus_enable, mcu_enable,
                             oversample_enable, fixed_split_enable,
                             digital_io_enable, spi_slave_enable,
                             bridge_port3_enable};
  logic        core_mirror, core_sync, core_latch;
  wire logic [7:0] core_units = {5'h0, core_latch, core_sync, core_mirror};
  wire logic [7:0] units = {5'h0, latch_in_run, sync_out_run, state_mirror_on};
  wire logic [7:0] link = {4'h0, link_enhanced};
  int          n_mismatch = 0;
  int          num_checks = 0;

  ifc_interface_feature_config dut (.*);
  ifc_eeprom_model u_ee (.*);

  // Core variant beside the silicon one; only its unit bits are watched
  ifc_interface_feature_config #(
    .VARIANT       (IFC_CORE),
    .CORE_SELECT   (SEL_DIGITAL_IO),
    .CORE_SYNC_OUT (1'b1),
    .CORE_LATCH_IN (1'b0)
  ) dut_core (
    .clock                  (clock),
    .reset                  (reset),
    .eeprom_load            (eeprom_load),
    .eeprom_word0           (eeprom_word0),
    .state_mirror_strap_pin (state_mirror_strap_pin),
    .network_side_read      (network_side_read),
    .network_side_write     (network_side_write),
    .network_side_addr      (network_side_addr),
    .network_side_wdata     (network_side_wdata),
    .network_side_rdata     (),
    .host_data_port_read    (host_data_port_read),
    .host_data_port_write   (host_data_port_write),
    .host_data_port_addr    (host_data_port_addr),
    .host_data_port_wdata   (host_data_port_wdata),
    .host_data_port_rdata   (),
    .digital_io_enable      (),
    .spi_slave_enable       (),
    .bridge_port3_enable    (),
    .oversample_enable      (),
    .mcu_enable             (),
    .on_chip_bus_enable     (),
    .fixed_split_enable     (),
    .fixed_input_count      (),
    .fixed_output_count     (),
    .link_enhanced          (),
    .sync_out_run           (core_sync),
    .latch_in_run           (core_latch),
    .state_mirror_on        (core_mirror),
    .state_request          (),
    .state_report           ()
  );
  always #5 clock = ~clock;

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Strobe held for one edge; read data lands on that same edge
  task automatic acc(input bit h, w, input logic [15:0] a,
                     input logic [7:0] d);
    @(posedge clock);
    {host_data_port_read, host_data_port_write} <= {h & !w, h & w};
    {network_side_read, network_side_write} <= {!h & !w, !h & w};
    {network_side_addr, host_data_port_addr} <= {a, a};
    {network_side_wdata, host_data_port_wdata} <= {d, d};
    @(posedge clock);
    {host_data_port_read, host_data_port_write} <= 2'h0;
    {network_side_read, network_side_write} <= 2'h0;
    #1;
  endtask

  task automatic rd(input bit h, input logic [15:0] a, input logic [7:0] e,
                    input string nm);
    acc(h, 1'b0, a, 8'h00);
    chk(nm, h ? host_data_port_rdata : network_side_rdata, e);
  endtask

  task automatic ld(input logic [15:0] w);
    u_ee.load(w);
    #1;
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    close_out;
  end

  initial
  begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    rd(0, 16'h0140, 8'h00, "select");
    rd(1, 16'h0141, 8'hf2, "feature");
    chk("core units", core_units, 8'h03);
    ld(16'h5004);
    chk("link", link, 8'h05);
    foreach (codes[i])
    begin
      c = codes[i];
      ld({8'h0d, c});
      chk("io", io_sel, {1'b0, c == 8'h80, c == 8'h08, c == 8'h06,
                         (c == 8'h10) || (c == 8'h11), c == 8'h04,
                         c == 8'h05, c == 8'h07});
      chk("in", {2'h0, fixed_input_count}, ins[i]);
      chk("out", {2'h0, fixed_output_count}, outs[i]);
      rd(1, 16'h0140, c, "select");
    end
    rd(0, 16'h0141, 8'h5d, "feature");
    chk("units", units, 8'h07);
    chk("core units", core_units, 8'h03);
    chk("link", link, 8'h05);
    acc(0, 1, 16'h0120, 8'h02);
    chk("request", state_request, 8'h02);
    chk("report", state_report, 8'h02);
    acc(1, 1, 16'h0130, 8'h08);
    chk("report", state_report, 8'h02);
    acc(0, 1, 16'h0141, 8'h00);
    acc(1, 1, 16'h0140, 8'h00);
    rd(1, 16'h0141, 8'h5d, "feature");
    rd(0, 16'h0140, 8'h11, "select");
    rd(1, 16'h0150, 8'h00, "unmapped");
    ld(16'h0004);
    chk("units", units, 8'h00);
    acc(1, 1, 16'h0130, 8'h04);
    chk("report", state_report, 8'h04);
    @(posedge clock);
    reset <= 1'b1;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    ld(16'h0204);
    chk("link", link, 8'h0f);
    chk("core units", core_units, 8'h03);
    ld(16'h0004);
    rd(0, 16'h0141, 8'h02, "feature");
    close_out;
  end
endmodule // ifc_interface_feature_config_tb
